// ### rtl/sqerr_core.sv
// Seek sequencing, travel limit recovery and seek error detection.
//
// Our own choices: the register offsets and the plain strobed port.
module sqerr_core #(
    parameter int TIMEOUT_CYC = sqerr_pkg::SEEK_TIMEOUT_CYC
) (
    input wire logic CLOCK_I,
    input wire logic RST_N_I,
    input wire logic CE_I,
    input wire sqerr_pkg::sqerr_cmd_t CMD_I,
    input wire logic [9:0] SEEK_CYL_I,
    input wire logic SEEK_REQ_I,
    input wire sqerr_pkg::sqerr_servo_t SERVO_I,
    input wire logic [7:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [7:0] RDATA_O,
    output logic [7:0] BUS_IN_O,
    output logic SEEK_END_O,
    output logic ON_CYL_O,
    output logic SEEK_ERROR_O,
    output logic RTZ_GATE_O,
    output logic LOAD_GATE_O,
    output logic COARSE_GATE_O,
    output logic FINE_GATE_O,
    output logic FWD_DIR_O,
    output logic ACTUATOR_ON_O,
    output logic [9:0] DIFF_CNT_O,
    output logic EVEN_ODD_SLOPE_O
);
    import sqerr_pkg::*;

    sqerr_regs_t r_q;
    sqerr_regs_t r_d;

    // ==========================================================
    // Next-state logic.
    always_comb begin
        logic rtz_cmd;
        logic eot_en;
        logic gap;
        logic [9:0] max_cyl;
        r_d = r_q;
        rtz_cmd = CMD_I.tag_strobe && CMD_I.tag == TAG_DIAG
            && CMD_I.bus_out[BO_RTZ];
        max_cyl = r_q.run[RUN_HALF_CAP] ? MAX_CYL_HALF : MAX_CYL_FULL;
        eot_en = (r_q.state != SQ_UNLOAD);
        r_d.rd_valid = RD_I;
        r_d.rd_data = 8'h00;
        if (RD_I) begin
            case (ADDR_I)
                ADDR_RUN: r_d.rd_data = {6'h00, r_q.run};
                ADDR_STATUS: r_d.rd_data = {r_q.seek_end, r_q.on_cyl,
                    r_q.seek_error, r_q.fwd_limit, r_q.rev_limit,
                    r_q.rtz_latch, r_q.load_latch, r_q.fine_latch};
                default: r_d.rd_data = 8'h00;
            endcase
        end
        if (WR_I && ADDR_I == ADDR_RUN) begin
            r_d.run = WDATA_I[1:0];
        end
        // Integrator models the gap since the last cylinder pulse.
        if (SERVO_I.cyl_pulse) begin
            r_d.integ = '0;
        end else if (r_q.integ < EOT_GAP_CYC) begin
            r_d.integ = r_q.integ + 32'h1;
        end
        gap = eot_en && (r_q.integ >= EOT_GAP_CYC);
        if (r_q.timer != 32'h0) begin
            r_d.timer = r_q.timer - 32'h1;
        end
        r_d.on_cyl = SERVO_I.on_cyl_det && r_q.fine_latch;
        if (r_d.on_cyl && !r_q.on_cyl) begin
            r_d.seek_end = 1'b1;
            r_d.seek_active = 1'b0;
        end
        case (r_q.state)
            SQ_IDLE: begin
                if (SEEK_REQ_I && !r_q.seek_error) begin
                    r_d.seek_end = 1'b0;
                    if (SEEK_CYL_I > max_cyl) begin
                        r_d.seek_error = 1'b1;
                        r_d.seek_end = 1'b1;
                    end else begin
                        r_d.state = SQ_SEEK;
                        r_d.seek_active = 1'b1;
                        r_d.diff_cnt = SEEK_CYL_I;
                        r_d.slope = SEEK_CYL_I[0];
                        r_d.fine_latch = 1'b0;
                        r_d.timer = TIMEOUT_CYC;
                        r_d.on_cyl = 1'b0;
                    end
                end
            end
            SQ_SEEK: begin
                if (SERVO_I.cyl_pulse && r_q.diff_cnt != 10'h000) begin
                    r_d.diff_cnt = r_q.diff_cnt - 10'h001;
                end
                if (gap && SERVO_I.outside_area) begin
                    r_d.fwd_limit = 1'b1;
                    r_d.seek_error = 1'b1;
                    r_d.seek_active = 1'b0;
                    r_d.diff_cnt = CYL_ZERO;
                    r_d.slope = 1'b0;
                    r_d.seek_end = 1'b1;
                    r_d.state = SQ_FWD_EOT;
                end else if (r_q.timer == 32'h1 && !r_q.on_cyl) begin
                    r_d.seek_error = 1'b1;
                    r_d.diff_cnt = CYL_ZERO;
                    r_d.slope = 1'b0;
                    r_d.seek_end = 1'b1;
                    r_d.seek_active = 1'b0;
                    r_d.state = SQ_IDLE;
                end else if (r_q.on_cyl) begin
                    r_d.state = SQ_IDLE;
                end
            end
            SQ_RTZ_REV1: begin
                if (gap) begin
                    r_d.rev_limit = 1'b1;
                    r_d.integ = '0;
                    r_d.state = SQ_RTZ_REV2;
                end
            end
            SQ_RTZ_REV2: begin
                if (gap) begin
                    r_d.load_latch = 1'b1;
                    r_d.rtz_latch = 1'b0;
                    r_d.state = SQ_LOAD;
                end
            end
            SQ_LOAD: begin
                if (SERVO_I.neg_even_dibits) begin
                    r_d.rev_limit = 1'b0;
                    r_d.load_latch = 1'b0;
                    r_d.diff_cnt = CYL_ZERO;
                    r_d.slope = 1'b0;
                    r_d.state = SQ_IDLE;
                end
            end
            SQ_FWD_EOT: begin
                r_d.state = SQ_FWD_EOT;
            end
            SQ_UNLOAD: begin
                if (!SERVO_I.heads_loaded) begin
                    r_d.rtz_latch = 1'b0;
                    r_d.state = SQ_IDLE;
                end
            end
            default: r_d.state = SQ_IDLE;
        endcase
        // Reverse limit hit during a seek with SEEK_CYL_I at zero and diff_cnt not zero also runs a load back to zero.
        if (r_q.state == SQ_SEEK && gap && !SERVO_I.outside_area
            && r_q.diff_cnt != 10'h000 && SEEK_CYL_I == CYL_ZERO) begin
            r_d.rev_limit = 1'b1;
            r_d.seek_error = 1'b1;
            r_d.seek_end = 1'b1;
            r_d.seek_active = 1'b0;
            r_d.load_latch = 1'b1;
            r_d.state = SQ_LOAD;
        end
        if (rtz_cmd && r_q.state != SQ_UNLOAD) begin
            r_d.seek_error = 1'b0;
            r_d.fwd_limit = 1'b0;
            r_d.rtz_latch = 1'b1;
            r_d.load_latch = 1'b0;
            r_d.seek_end = 1'b0;
            r_d.on_cyl = 1'b0;
            r_d.integ = '0;
            r_d.state = SQ_RTZ_REV1;
        end
        if (r_q.run[RUN_POWER_OFF] && r_q.state != SQ_UNLOAD
            && SERVO_I.heads_loaded) begin
            r_d.rtz_latch = 1'b1;
            r_d.load_latch = 1'b0;
            r_d.state = SQ_UNLOAD;
        end
        // Fine latch is jammed while either coarse latch is set.
        if (r_d.load_latch || r_d.rtz_latch) begin
            r_d.fine_latch = 1'b0;
        end else if (!SERVO_I.heads_loaded) begin
            // Unloaded heads must leave the voice coil without current.
            r_d.fine_latch = 1'b0;
        end else if (r_d.diff_cnt == 10'h000
            && r_d.state != SQ_SEEK) begin
            r_d.fine_latch = 1'b1;
        end else if (r_q.state == SQ_SEEK && r_d.diff_cnt == 10'h000) begin
            r_d.fine_latch = 1'b1;
        end
        r_d.bus_in = 8'h00;
        if (CMD_I.tag_strobe && (CMD_I.tag == TAG_LOW_CYL
            || CMD_I.tag == TAG_CONTROL)) begin
            r_d.bus_in[BI_ON_CYL] = r_q.on_cyl && !r_q.seek_error;
            r_d.bus_in[BI_CHECK_DIAG] = r_q.seek_error;
        end
    end

    // ==========================================================
    // State register.
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            r_q <= '{state: SQ_IDLE, default: '0};
        end else if (CE_I) begin
            r_q <= r_d;
        end
    end

    // ==========================================================
    // Outputs.
    assign RDATA_O = r_q.rd_valid ? r_q.rd_data : 8'h00;
    assign BUS_IN_O = r_q.bus_in;
    assign SEEK_END_O = r_q.seek_end;
    assign ON_CYL_O = r_q.on_cyl && !r_q.seek_error;
    assign SEEK_ERROR_O = r_q.seek_error;
    assign RTZ_GATE_O = r_q.rtz_latch;
    assign LOAD_GATE_O = r_q.load_latch;
    assign COARSE_GATE_O = r_q.seek_active && !r_q.fine_latch
        && !r_q.load_latch && !r_q.rtz_latch;
    assign FINE_GATE_O = r_q.fine_latch;
    assign FWD_DIR_O = !r_q.rtz_latch;
    assign ACTUATOR_ON_O = r_q.rtz_latch || r_q.load_latch
        || r_q.seek_active || r_q.fine_latch;
    assign DIFF_CNT_O = r_q.diff_cnt;
    assign EVEN_ODD_SLOPE_O = r_q.slope;
endmodule

// ### pkg/sqerr_pkg.sv
// Package with constants, states and carrier types of the seek sequencer.
package sqerr_pkg;
    localparam int CLK_HZ = 40000000;
    localparam int SEEK_TIMEOUT_MS = 500;
    localparam int SEEK_TIMEOUT_CYC = (CLK_HZ / 1000) * SEEK_TIMEOUT_MS;
    localparam int EOT_GAP_US = 10;
    localparam int EOT_GAP_CYC = (CLK_HZ / 1000000) * EOT_GAP_US;
    localparam logic [9:0] MAX_CYL_FULL = 10'd822;
    localparam logic [9:0] MAX_CYL_HALF = 10'd410;
    localparam logic [9:0] CYL_ZERO = 10'h000;
    localparam logic [2:0] TAG_DIAG = 3'h2;
    localparam logic [2:0] TAG_LOW_CYL = 3'h6;
    localparam logic [2:0] TAG_CONTROL = 3'h7;
    localparam int BI_ON_CYL = 2;
    localparam int BI_CHECK_DIAG = 7;
    localparam int BO_RTZ = 0;
    localparam logic [7:0] ADDR_RUN = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam int RUN_POWER_OFF = 0;
    localparam int RUN_HALF_CAP = 1;

    typedef enum logic [2:0] {
        SQ_IDLE, SQ_SEEK, SQ_RTZ_REV1, SQ_RTZ_REV2, SQ_LOAD, SQ_FWD_EOT,
        SQ_UNLOAD
    } sqerr_state_t;

    typedef struct packed {
        logic [2:0] tag;
        logic [7:0] bus_out;
        logic       tag_strobe;
    } sqerr_cmd_t;

    typedef struct packed {
        logic cyl_pulse;
        logic neg_even_dibits;
        logic heads_loaded;
        logic on_cyl_det;
        logic outside_area;
    } sqerr_servo_t;

    typedef struct packed {
        sqerr_state_t state;
        logic [31:0]  timer;
        logic [31:0]  integ;
        logic         rtz_latch;
        logic         load_latch;
        logic         fine_latch;
        logic         fwd_limit;
        logic         rev_limit;
        logic         seek_error;
        logic         seek_active;
        logic         slope;
        logic         on_cyl;
        logic         seek_end;
        logic [9:0]   diff_cnt;
        logic [7:0]   bus_in;
        logic         rd_valid;
        logic [7:0]   rd_data;
        logic [1:0]   run;
    } sqerr_regs_t;
endpackage

// ### verif/sqerr_core_chk.sv
// Port checker for the seek sequencer, bound to its top module.
module sqerr_core_chk #(
    parameter int TIMEOUT_CYC = 200
) (
    input wire logic CLOCK_I,
    input wire logic RST_N_I,
    input wire sqerr_pkg::sqerr_cmd_t CMD_I,
    input wire logic [9:0] SEEK_CYL_I,
    input wire logic SEEK_REQ_I,
    input wire sqerr_pkg::sqerr_servo_t SERVO_I,
    input wire logic [7:0] BUS_IN_O,
    input wire logic SEEK_END_O,
    input wire logic ON_CYL_O,
    input wire logic SEEK_ERROR_O,
    input wire logic RTZ_GATE_O,
    input wire logic LOAD_GATE_O,
    input wire logic COARSE_GATE_O,
    input wire logic FINE_GATE_O
);
    import sqerr_pkg::*;
    logic busy_q;
    int cnt_q;
    logic poll;
    logic rtz_cmd;
    assign poll = CMD_I.tag_strobe && CMD_I.tag[2:1] == 2'h3;
    assign rtz_cmd = CMD_I.tag_strobe && CMD_I.tag == TAG_DIAG
        && CMD_I.bus_out[BO_RTZ];
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (!RST_N_I);
    // ========
    // Counts the cycles of the seek in progress.
    always_ff @(posedge CLOCK_I) begin
        if (!RST_N_I) begin
            busy_q <= 1'b0;
            cnt_q <= 0;
        end else if (SEEK_REQ_I && !SEEK_ERROR_O) begin
            busy_q <= 1'b1;
            cnt_q <= 0;
        end else if (SEEK_END_O) begin
            busy_q <= 1'b0;
        end else if (busy_q) begin
            cnt_q <= cnt_q + 1;
        end
    end
    // ========
    // Assertions.
    jam_gates_a: assert property ((RTZ_GATE_O || LOAD_GATE_O) |->
        !FINE_GATE_O && !COARSE_GATE_O) else $error("gate open");
    err_end_a: assert property ($rose(SEEK_ERROR_O) |->
        ##[0:2] SEEK_END_O) else $error("no seek end");
    refuse_seek_a: assert property (SEEK_ERROR_O && SEEK_END_O &&
        SEEK_REQ_I && !CMD_I.tag_strobe |=> SEEK_END_O && SEEK_ERROR_O)
        else $error("seek taken");
    poll_reply_a: assert property (poll |=>
        BUS_IN_O[BI_CHECK_DIAG] == $past(SEEK_ERROR_O) &&
        BUS_IN_O[BI_ON_CYL] == ($past(ON_CYL_O) && !$past(SEEK_ERROR_O)))
        else $error("bad bus in");
    max_addr_a: assert property (SEEK_REQ_I && !SEEK_ERROR_O &&
        SEEK_CYL_I > MAX_CYL_FULL |=> SEEK_ERROR_O) else $error("no error");
    rtz_cmd_a: assert property (rtz_cmd |=>
        RTZ_GATE_O && !SEEK_ERROR_O) else $error("no retract");
    unload_a: assert property ($fell(SERVO_I.heads_loaded) |->
        ##[1:2] !RTZ_GATE_O) else $error("retract held");
    on_cyl_end_a: assert property ($rose(ON_CYL_O) |->
        ##[0:1] SEEK_END_O) else $error("no seek end");
    seek_time_a: assert property (cnt_q <= TIMEOUT_CYC + 4)
        else $error("seek too long");
    cover property ($rose(LOAD_GATE_O));
    cover property ($rose(SEEK_ERROR_O));
    cover property ($fell(RTZ_GATE_O));
endmodule

bind sqerr_core sqerr_core_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) chk_i (.*);

// ### verif/sqerr_ctl_model.sv
// Controller model that strobes tagged commands and samples Bus In.
module sqerr_ctl_model (
    input wire logic clk_i,
    input wire logic [7:0] bus_in_i,
    output sqerr_pkg::sqerr_cmd_t cmd_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import sqerr_pkg::*;
    initial cmd_o = '0;
    // After a command the idle lines carry its inverse pattern (all zero before the first) so stale values cannot pass.
    task automatic send_tag(input logic [2:0] t, input logic [7:0] bo,
            output logic [7:0] rsp);
        @(posedge clk_i);
        cmd_o <= '{tag: t, bus_out: bo, tag_strobe: 1'b1};
        @(posedge clk_i);
        cmd_o <= '{tag: ~t, bus_out: ~bo, tag_strobe: 1'b0};
        #1 rsp = bus_in_i;
    endtask
endmodule

// ### verif/test_sqerr_core.sv
// Self-checking bench for the seek sequencer.
module test_sqerr_core;
    timeunit 1ns;
    timeprecision 1ps;
    import sqerr_pkg::*;
    localparam int TMO = 600;
    logic clk = 1'b0, rst_n = 1'b0, req = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [9:0] cyl = 10'h000, diff;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, bus_in, s;
    sqerr_cmd_t cmd;
    sqerr_servo_t servo = 5'h04;
    logic sk_end, on_cyl, sk_err, return_to_cylinder_zero, load, fine, fwd, act, slope;
    int err_count = 0, total_checks = 0;
    sqerr_core #(.TIMEOUT_CYC(TMO)) sqerr_core_i (.CLOCK_I(clk),
        .RST_N_I(rst_n), .CE_I(1'b1), .CMD_I(cmd), .SEEK_CYL_I(cyl),
        .SEEK_REQ_I(req), .SERVO_I(servo), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .BUS_IN_O(bus_in),
        .SEEK_END_O(sk_end), .ON_CYL_O(on_cyl), .SEEK_ERROR_O(sk_err),
        .RTZ_GATE_O(return_to_cylinder_zero), .LOAD_GATE_O(load), .COARSE_GATE_O(),
        .FINE_GATE_O(fine), .FWD_DIR_O(fwd), .ACTUATOR_ON_O(act),
        .DIFF_CNT_O(diff), .EVEN_ODD_SLOPE_O(slope));
    sqerr_ctl_model ctl_i (.clk_i(clk), .bus_in_i(bus_in), .cmd_o(cmd));
    initial forever #12.5 clk = ~clk;
    // ========
    // Tasks.
    task automatic chk(input logic [9:0] got, input logic [9:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic reset_dut();
        rst_n <= 1'b0;
        servo <= 5'h04;
        tick(6);
        rst_n <= 1'b1;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= w;
        rd <= !w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        #1 s = rdata;
    endtask
    task automatic seek(input logic [9:0] c);
        @(posedge clk);
        cyl <= c;
        req <= 1'b1;
        tick(1);
        req <= 1'b0;
    endtask
    task automatic pulse(input int n);
        repeat (n) begin
            tick(20);
            servo.cyl_pulse <= 1'b1;
            tick(1);
            servo.cyl_pulse <= 1'b0;
        end
    endtask
    task automatic wait_end(input int n);
        for (int i = 0; i < n && sk_end !== 1'b1; i++) tick(1);
        chk(sk_end, 1'b1);
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        report_and_stop();
    end
    // ========
    // Tests.
    initial begin
        reset_dut();
        bus(1'b0, 8'h08, 8'h00);
        chk(s, 8'h00);
        seek(10'h003);
        chk(sk_end, 1'b0);
        pulse(3);
        tick(2);
        chk(fine, 1'b1);
        servo.on_cyl_det <= 1'b1;
        wait_end(10);
        chk(on_cyl, 1'b1);
        ctl_i.send_tag(TAG_LOW_CYL, 8'h00, s);
        chk(s, 8'h04);
        $display("clean seek done");
        reset_dut();
        seek(10'h002);
        pulse(2);
        tick(TMO - 100);
        chk(sk_err, 1'b0);
        wait_end(120);
        chk(sk_err, 1'b1);
        chk(diff, 10'h000);
        chk(slope, 1'b0);
        ctl_i.send_tag(TAG_CONTROL, 8'h00, s);
        chk(s, 8'h80);
        seek(10'h001);
        tick(3);
        chk(sk_err & sk_end, 1'b1);
        $display("timeout done");
        for (int k = 0; k < 2; k++) begin
            reset_dut();
            bus(1'b1, ADDR_RUN, k ? 8'h02 : 8'h00);
            seek(k ? 10'h19B : 10'h337);
            wait_end(3);
            chk(sk_err, 1'b1);
            chk(diff, 10'h000);
        end
        $display("address limit done");
        reset_dut();
        seek(10'h005);
        servo.outside_area <= 1'b1;
        wait_end(600);
        chk(sk_err, 1'b1);
        chk(diff, 10'h000);
        tick(3);
        chk(fine, 1'b1);
        bus(1'b0, ADDR_STATUS, 8'h00);
        chk(s & 8'h10, 8'h10);
        servo.outside_area <= 1'b0;
        ctl_i.send_tag(TAG_DIAG, 8'h01, s);
        chk({return_to_cylinder_zero, sk_err, fwd}, 3'h4);
        pulse(1);
        tick(580);
        bus(1'b0, ADDR_STATUS, 8'h00);
        chk(s & 8'h0E, 8'h0C);
        tick(400);
        bus(1'b0, ADDR_STATUS, 8'h00);
        chk(s & 8'h0E, 8'h0A);
        chk({fwd, fine}, 2'h2);
        servo.neg_even_dibits <= 1'b1;
        tick(1);
        servo.neg_even_dibits <= 1'b0;
        tick(3);
        bus(1'b0, ADDR_STATUS, 8'h00);
        chk(s & 8'h0B, 8'h01);
        $display("travel limit done");
        reset_dut();
        bus(1'b1, ADDR_RUN, 8'h01);
        tick(900);
        chk({return_to_cylinder_zero, load}, 2'h2);
        servo.heads_loaded <= 1'b0;
        tick(3);
        chk({return_to_cylinder_zero, act}, 2'h0);
        $display("unload done");
        report_and_stop();
    end
endmodule
